// File: rpm_cfg.svh
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_POWER_CONTROL   12'h000
`define ADDR_AUX_CONTROL     12'h004
`define ADDR_SERIAL_BUFFER   12'h008
`define ADDR_PORT_LATCH      12'h00C
`define ADDR_STACK_POINTER   12'h010
`define ADDR_IRQ_ENABLE      12'h014
`define ADDR_STATUS          12'h018
// ****************************************
// fields and reset values
// ****************************************
`define BIT_IDLE             0
`define BIT_PDOWN            1
`define BIT_FLAG4            4
`define BIT_AUX_DISABLE      1
`define BIT_EX0              0
`define BIT_EX1              2
`define RST_PORT             32'h000000FF
`define RST_SP               8'h07
`define RST_ZERO             8'h00
// ****************************************
// timing
// ****************************************
`define CLK_PER_MC           4'hB
`define SAMPLE_PHASE         4'h9
`define RESET_MIN_SAMPLES    2'h2
`endif

// File: rpm_pkg.sv
package rpm_pkg;
  typedef enum logic [2:0] {
    RUN   = 3'b001,
    IDLE  = 3'b010,
    PDOWN = 3'b100
  } mode_e;

  typedef struct packed {
    mode_e       mode;
    logic [3:0]  phase;
    logic [1:0]  high_count;
    logic        chip_reset;
    logic [7:0]  power_control;
    logic [7:0]  aux_control;
    logic [7:0]  serial_buffer;
    logic [31:0] port_latch;
    logic [7:0]  stack_pointer;
    logic [7:0]  irq_enable;
    logic [31:0] prdata;
    logic [1:0]  rst_sync;
    logic [1:0]  external_interrupt_0_sync;
    logic [1:0]  external_interrupt_1_sync;
  } state_s;
endpackage : rpm_pkg

// File: reset_and_power_mode_control.sv
`include "rpm_cfg.svh"
module reset_and_power_mode_control (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        RESET_PIN,
  input  wire logic        INTERRUPT_PENDING,
  input  wire logic        EXTERNAL_INTERRUPT_0,
  input  wire logic        EXTERNAL_INTERRUPT_1,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             CPU_CLOCK_EN,
  output logic             PERIPH_CLOCK_EN,
  output logic             OSC_EN,
  output logic             CHIP_RESET,
  output logic             AUX_RAM_EN,
  output logic [31:0]      PORT_LATCH,
  output logic [7:0]       STACK_POINTER
);
  rpm_pkg::state_s s;
  rpm_pkg::state_s next_s;
  logic            wr;
  logic            rd;
  logic            wake_pd;
  logic            sample;
  logic            rst_hit;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  // ****************************************
  // combinational next state
  // ****************************************
  always_comb begin
    next_s = s;
    wr = PSEL && PENABLE && PWRITE;
    // read data loaded in setup so it stands through the access phase
    rd = PSEL && !PENABLE && !PWRITE;
    // ****************************************
    // pin synchronisers
    // ****************************************
    next_s.rst_sync = {s.rst_sync[0], RESET_PIN};
    next_s.external_interrupt_0_sync = {s.external_interrupt_0_sync[0], EXTERNAL_INTERRUPT_0};
    next_s.external_interrupt_1_sync = {s.external_interrupt_1_sync[0], EXTERNAL_INTERRUPT_1};
    // machine cycle phase counter freezes while oscillator stops
    sample = (s.phase == `SAMPLE_PHASE) && (s.mode != rpm_pkg::PDOWN);
    wake_pd = (s.external_interrupt_0_sync[1] && s.irq_enable[`BIT_EX0]) ||
              (s.external_interrupt_1_sync[1] && s.irq_enable[`BIT_EX1]);
    if (s.mode != rpm_pkg::PDOWN) begin
      next_s.phase = (s.phase == `CLK_PER_MC) ? 4'h0 : s.phase + 4'h1;
    end
    if (sample) begin
      if (s.rst_sync[1]) begin
        if (s.high_count != `RESET_MIN_SAMPLES) begin
          next_s.high_count = s.high_count + 2'h1;
        end
      end else begin
        next_s.high_count = 2'h0;
      end
    end
    // chip reset only after the filter saw enough high samples
    rst_hit = (s.high_count == `RESET_MIN_SAMPLES);
    next_s.chip_reset = rst_hit;
    // pin reset in power-down restarts the machine cycle from its start
    if (s.mode == rpm_pkg::PDOWN && s.rst_sync[1]) begin
      next_s.phase = 4'h0;
    end
    // ****************************************
    // register writes
    // ****************************************
    if (wr) begin
      if (hit(PADDR, `ADDR_POWER_CONTROL)) next_s.power_control = PWDATA[7:0];
      if (hit(PADDR, `ADDR_AUX_CONTROL)) next_s.aux_control = PWDATA[7:0];
      if (hit(PADDR, `ADDR_SERIAL_BUFFER)) next_s.serial_buffer = PWDATA[7:0];
      if (hit(PADDR, `ADDR_PORT_LATCH)) next_s.port_latch = PWDATA;
      if (hit(PADDR, `ADDR_STACK_POINTER)) next_s.stack_pointer = PWDATA[7:0];
      if (hit(PADDR, `ADDR_IRQ_ENABLE)) next_s.irq_enable = PWDATA[7:0];
    end
    // ****************************************
    // power modes
    // ****************************************
    unique case (s.mode)
      rpm_pkg::RUN: begin
        if (next_s.power_control[`BIT_PDOWN]) begin
          next_s.mode = rpm_pkg::PDOWN;
        end else if (next_s.power_control[`BIT_IDLE]) begin
          next_s.mode = rpm_pkg::IDLE;
        end
      end
      rpm_pkg::IDLE: begin
        if (INTERRUPT_PENDING) begin
          next_s.mode = rpm_pkg::RUN;
          next_s.power_control[`BIT_IDLE] = 1'b0;
        end
      end
      rpm_pkg::PDOWN: begin
        if (wake_pd || s.rst_sync[1]) begin
          next_s.mode = rpm_pkg::RUN;
          next_s.power_control[`BIT_PDOWN] = 1'b0;
        end
      end
    endcase
    if (rd) begin
      unique case (PADDR)
        `ADDR_POWER_CONTROL: next_s.prdata = {24'h000000, s.power_control};
        `ADDR_AUX_CONTROL:   next_s.prdata = {24'h000000, s.aux_control};
        `ADDR_SERIAL_BUFFER: next_s.prdata = {24'h000000, s.serial_buffer};
        `ADDR_PORT_LATCH:    next_s.prdata = s.port_latch;
        `ADDR_STACK_POINTER: next_s.prdata = {24'h000000, s.stack_pointer};
        `ADDR_IRQ_ENABLE:    next_s.prdata = {24'h000000, s.irq_enable};
        `ADDR_STATUS:        next_s.prdata = {28'h0000000, s.chip_reset, s.mode};
        default:             next_s.prdata = 32'h00000000;
      endcase
    end
    // ****************************************
    // chip reset values
    // ****************************************
    if (s.chip_reset) begin
      next_s.mode = rpm_pkg::RUN;
      next_s.port_latch = `RST_PORT;
      next_s.stack_pointer = `RST_SP;
      next_s.aux_control = `RST_ZERO;
      next_s.irq_enable = `RST_ZERO;
      next_s.power_control = s.power_control & (8'h01 << `BIT_FLAG4);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s <= '{mode: rpm_pkg::RUN, phase: 4'h0, high_count: 2'h0, chip_reset: 1'b0,
             power_control: `RST_ZERO, aux_control: `RST_ZERO,
             serial_buffer: `RST_ZERO, port_latch: `RST_PORT,
             stack_pointer: `RST_SP, irq_enable: `RST_ZERO,
             prdata: 32'h00000000, rst_sync: 2'h0,
             external_interrupt_0_sync: 2'h0, external_interrupt_1_sync: 2'h0};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PREADY          = 1'b1;
  assign PSLVERR         = 1'b0;
  assign PRDATA          = s.prdata;
  assign CPU_CLOCK_EN    = (s.mode == rpm_pkg::RUN);
  assign PERIPH_CLOCK_EN = (s.mode != rpm_pkg::PDOWN);
  assign OSC_EN          = (s.mode != rpm_pkg::PDOWN);
  assign CHIP_RESET      = s.chip_reset;
  assign AUX_RAM_EN      = !s.aux_control[`BIT_AUX_DISABLE];
  assign PORT_LATCH      = s.port_latch;
  assign STACK_POINTER   = s.stack_pointer;

  // ****************************************
  // assertions
  // ****************************************
  a_reset_values: assert property (@(posedge REF_CLK) disable iff (RST)
    s.chip_reset |=> (PORT_LATCH == `RST_PORT && STACK_POINTER == `RST_SP))
    else $error("reset values not loaded");
  a_reset_clears_modes: assert property (@(posedge REF_CLK) disable iff (RST)
    s.chip_reset |=> (s.mode == rpm_pkg::RUN && !s.power_control[`BIT_IDLE] &&
                      !s.power_control[`BIT_PDOWN]))
    else $error("reset left a power mode");
  a_keep_flag4: assert property (@(posedge REF_CLK) disable iff (RST)
    s.chip_reset |=> s.power_control[`BIT_FLAG4] == $past(s.power_control[`BIT_FLAG4]))
    else $error("bit 4 cleared by reset");
  a_keep_serial_buffer: assert property (@(posedge REF_CLK) disable iff (RST)
    s.chip_reset |=> $stable(s.serial_buffer))
    else $error("serial buffer changed by reset");
  a_idle_clock: assert property (@(posedge REF_CLK) disable iff (RST)
    s.mode == rpm_pkg::IDLE |-> !CPU_CLOCK_EN && PERIPH_CLOCK_EN)
    else $error("idle clocks wrong");
  a_idle_wake: assert property (@(posedge REF_CLK) disable iff (RST)
    (s.mode == rpm_pkg::IDLE && INTERRUPT_PENDING) |=> CPU_CLOCK_EN)
    else $error("idle not left on interrupt");
  a_pd_osc: assert property (@(posedge REF_CLK) disable iff (RST)
    s.mode == rpm_pkg::PDOWN |-> !OSC_EN && !CPU_CLOCK_EN)
    else $error("oscillator running in power-down");
  a_pd_stay: assert property (@(posedge REF_CLK) disable iff (RST)
    (s.mode == rpm_pkg::PDOWN && !wake_pd && !s.rst_sync[1] && !s.chip_reset)
      |=> s.mode == rpm_pkg::PDOWN)
    else $error("power-down left without cause");
  a_reset_filter: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(s.chip_reset) |-> $past(s.high_count) == `RESET_MIN_SAMPLES)
    else $error("short reset pulse accepted");
  a_sample_phase: assert property (@(posedge REF_CLK) disable iff (RST)
    s.high_count != $past(s.high_count) |-> $past(s.phase) == `SAMPLE_PHASE)
    else $error("reset sampled off phase");
  a_aux_enable: assert property (@(posedge REF_CLK) disable iff (RST)
    s.chip_reset |=> AUX_RAM_EN)
    else $error("aux ram off after reset");
  a_pd_wake: assert property (@(posedge REF_CLK) disable iff (RST)
    (s.mode == rpm_pkg::PDOWN && wake_pd) |=> s.mode == rpm_pkg::RUN)
    else $error("enabled interrupt did not end power-down");
  a_pin_wake: assert property (@(posedge REF_CLK) disable iff (RST)
    (s.mode == rpm_pkg::PDOWN && s.rst_sync[1])
      |=> (s.mode == rpm_pkg::RUN && !s.power_control[`BIT_PDOWN]))
    else $error("reset pin did not end power-down");
  a_idle_reset: assert property (@(posedge REF_CLK) disable iff (RST)
    (s.mode == rpm_pkg::IDLE && s.chip_reset) |=> CPU_CLOCK_EN)
    else $error("idle not left on reset");
  a_idle_stay: assert property (@(posedge REF_CLK) disable iff (RST)
    (s.mode == rpm_pkg::IDLE && !INTERRUPT_PENDING && !s.chip_reset)
      |=> s.mode == rpm_pkg::IDLE)
    else $error("idle left without cause");
  c_idle: cover property (@(posedge REF_CLK) s.mode == rpm_pkg::IDLE ##1 CPU_CLOCK_EN);
  c_pin_wake: cover property (@(posedge REF_CLK)
    (s.mode == rpm_pkg::PDOWN && s.rst_sync[1]) ##1 s.mode == rpm_pkg::RUN);
  c_pdown: cover property (@(posedge REF_CLK) s.mode == rpm_pkg::PDOWN ##1 OSC_EN);
  c_reset: cover property (@(posedge REF_CLK) $rose(CHIP_RESET));
endmodule : reset_and_power_mode_control

// File: pin_model.sv
module pin_model (
  input  wire logic clk,
  output logic      reset_pin,
  output logic      ext_int_0,
  output logic      ext_int_1
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reset_pin = 1'b0;
    ext_int_0 = 1'b0;
    ext_int_1 = 1'b0;
  end
  // reset pin high for a number of clocks
  task automatic pulse_reset(input int n);
    @(posedge clk);
    reset_pin <= 1'b1;
    repeat (n) @(posedge clk);
    reset_pin <= 1'b0;
  endtask : pulse_reset
  // one external interrupt high for three clocks
  task automatic pulse_int(input int w);
    @(posedge clk);
    ext_int_0 <= (w == 0);
    ext_int_1 <= (w == 1);
    repeat (3) @(posedge clk);
    ext_int_0 <= 1'b0;
    ext_int_1 <= 1'b0;
  endtask : pulse_int
endmodule : pin_model

// File: tb_reset_and_power_mode_control.sv
`include "rpm_cfg.svh"
module tb_reset_and_power_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, intr = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, port, rv;
  logic        pready, perr, cpu, per, osc, crst, aux, rp, e0, e1;
  logic [7:0]  sp;
  int          num_errors = 0, checked = 0;
  always #50 clk = ~clk;
  pin_model i_pin_model (.clk(clk), .reset_pin(rp), .ext_int_0(e0), .ext_int_1(e1));
  reset_and_power_mode_control i_reset_and_power_mode_control (.REF_CLK(clk), .RST(rst),
    .RESET_PIN(rp), .INTERRUPT_PENDING(intr), .EXTERNAL_INTERRUPT_0(e0),
    .EXTERNAL_INTERRUPT_1(e1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .CPU_CLOCK_EN(cpu),
    .PERIPH_CLOCK_EN(per), .OSC_EN(osc), .CHIP_RESET(crst), .AUX_RAM_EN(aux),
    .PORT_LATCH(port), .STACK_POINTER(sp));
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prd;
    {psel, pen} <= 2'b00;
    tick(1);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rv, e);
  endtask : rd
  task automatic pulse_intr;
    @(posedge clk);
    intr <= 1'b1;
    @(posedge clk);
    intr <= 1'b0;
    tick(1);
  endtask : pulse_intr
  // **********
  // scenarios
  // **********
  task automatic t_reset;
    check(port, `RST_PORT);
    check(32'(sp), 32'h07);
    check(32'(aux), 32'h1);
    rd(`ADDR_STATUS, 32'h1);
    rd(12'h01C, 32'h0);
    check(32'(perr), 32'h0);
  endtask : t_reset
  task automatic t_idle;
    wr(`ADDR_POWER_CONTROL, 32'h01);
    tick(1);
    check({cpu, per, osc}, 3'b011);
    rd(`ADDR_STATUS, 32'h2);
    pulse_intr();
    check(32'(cpu), 32'h1);
    rd(`ADDR_POWER_CONTROL, 32'h0);
  endtask : t_idle
  task automatic t_pdown(input int w);
    wr(`ADDR_IRQ_ENABLE, (w == 1) ? 32'h4 : 32'h1);
    wr(`ADDR_POWER_CONTROL, 32'h03);
    tick(1);
    check({cpu, per, osc}, 3'b000);
    pulse_intr();
    i_pin_model.pulse_int(1 - w);
    tick(2);
    check(32'(osc), 32'h0);
    i_pin_model.pulse_int(w);
    tick(2);
    check({cpu, per, osc}, 3'b011);
    pulse_intr();
    check(32'(cpu), 32'h1);
    rd(`ADDR_POWER_CONTROL, 32'h0);
  endtask : t_pdown
  task automatic t_pin;
    logic g;
    g = 1'b0;
    wr(`ADDR_SERIAL_BUFFER, 32'hA5);
    wr(`ADDR_STACK_POINTER, 32'h40);
    wr(`ADDR_PORT_LATCH, 32'h12345678);
    wr(`ADDR_AUX_CONTROL, 32'h02);
    wr(`ADDR_POWER_CONTROL, 32'h11);
    check(32'(aux), 32'h0);
    i_pin_model.pulse_reset(11);
    for (int i = 0; i < 30; i++) begin
      tick(1);
      g |= crst;
    end
    check(32'(g), 32'h0);
    check(32'(sp), 32'h40);
    i_pin_model.pulse_reset(30);
    #1;
    check(32'(crst), 32'h1);
    check(port, `RST_PORT);
    check(32'(sp), 32'h07);
    tick(20);
    check({crst, aux, cpu}, 3'b011);
    rd(`ADDR_POWER_CONTROL, 32'h10);
    rd(`ADDR_SERIAL_BUFFER, 32'hA5);
    rd(`ADDR_AUX_CONTROL, 32'h0);
    wr(`ADDR_POWER_CONTROL, 32'h02);
    i_pin_model.pulse_reset(30);
    tick(20);
    check({crst, per, osc}, 3'b011);
    rd(`ADDR_STATUS, 32'h1);
  endtask : t_pin
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_idle();
    t_pdown(0);
    t_pdown(1);
    t_pin();
    give_verdict();
  end
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
endmodule : tb_reset_and_power_mode_control
